// ---- bench/axi_host_model.sv ----
`timescale 1ns/1ps
module axi_host_model (
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end
   // Handshakes are judged on the values that stand at the rising edge,
   // before the slave's registers move, and released right after it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ---- bench/dac_sfc_asserts.sv ----
`timescale 1ns/1ps
module dac_sfc_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic over_temp_pin,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [dac_sfc_pkg::NUM_CH*dac_sfc_pkg::DATA_W-1:0] dac_code,
   input wire logic amps_powered,
   input wire logic internal_reference_select,
   input wire logic reference_value_bit,
   input wire logic monitor_output_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_seen;
      s_axi_bvalid || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
   endsequence
   a_reset_out: assert property (disable iff (1'b0) sys_rst |=>
      amps_powered && !monitor_output_oe && dac_code == '0)
      else $error("outputs not at defaults after reset");
   a_reset_ref: assert property (disable iff (1'b0) sys_rst |=>
      !internal_reference_select && !reference_value_bit)
      else $error("reference not external after reset");
   a_amps_cause: assert property ($fell(amps_powered) |->
      $past(over_temp_pin) || $past(over_temp_pin, 2) ||
      $past(over_temp_pin, 3) || $past(over_temp_pin, 4))
      else $error("amplifiers powered down without over temperature");
   a_amps_recover: assert property (
      $rose(amps_powered) && !$past(sys_rst) |-> wr_seen)
      else $error("amplifiers powered up without a write");
   a_oe_cause: assert property (
      monitor_output_oe != $past(monitor_output_oe) |-> wr_seen)
      else $error("monitor enable changed without a write");
   a_bresp_hold: assert property ($fell(s_axi_bvalid) |->
      $past(s_axi_bready))
      else $error("write response dropped before accepted");
   a_rresp_hold: assert property ($fell(s_axi_rvalid) |->
      $past(s_axi_rready))
      else $error("read response dropped before accepted");
   a_write_block: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_lat: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
endmodule

// ---- bench/test_dac_special_function_control.sv ----
`timescale 1ns/1ps
module test_dac_special_function_control;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fifo_enable_pin = 1'b0;
   logic parallel_select_pin = 1'b1;
   logic over_temp_pin = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, amps_powered, monitor_output_oe;
   logic [dac_sfc_pkg::NUM_CH*dac_sfc_pkg::DATA_W-1:0] dac_code;
   logic internal_reference_select, reference_value_bit;
   logic [4:0] monitor_channel;
   logic [11:0] a, b, a2;
   logic [31:0] rv;
   logic [11:0] ex [5];
   int fails = 0;
   int check_count = 0;
   int g, ch, oc, m;
   always #2.5 clk = ~clk;
   dac_special_function_control #(.UPD_CYCLES_PER_CH(1)) dut_u (.*);
   axi_host_model host_u (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic logic [31:0] dw(input logic [1:0] s, input int c,
                                      input logic [11:0] d);
      return {13'h0000, s, c[4:0], d};
   endfunction
   function automatic logic [11:0] code(input int c);
      return dac_code[c*dac_sfc_pkg::DATA_W +: dac_sfc_pkg::DATA_W];
   endfunction
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      host_u.wr(ad, d, rsp);
   endtask
   task automatic strobe();
      wr(dac_sfc_pkg::ADDR_STROBE, 32'h0);
      repeat (40) @(posedge clk);
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h9683A2E4));
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({amps_powered, internal_reference_select}, 32'h2);
      chk(dac_code[31:0], 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(dac_sfc_pkg::ADDR_CTRL, {21'h0, i[1], 1'b0, i[0], 8'h00});
         chk({reference_value_bit, internal_reference_select}, i[1:0]);
      end
      wr(8'h40, 32'h0);
      chk(rsp, dac_sfc_pkg::RESP_SLVERR);
      g = $urandom_range(3);
      ch = g * 8 + $urandom_range(7);
      oc = (ch + 8) % 32;
      a = 12'($urandom);
      b = 12'($urandom);
      a2 = ~a;
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_B, ch, b));
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_CTRL, 12, 12'h001 << g));
      chk(rsp, dac_sfc_pkg::RESP_OKAY);
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_A, ch, a));
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_A, oc, a2));
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_B, oc, b));
      ex = '{a, 12'h000, a, b, a};
      for (int n = 0; n < 5; n++) begin
         if (n == 2) begin
            wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_B, ch, b));
         end
         if (n == 4) begin
            wr(dac_sfc_pkg::ADDR_CTRL, 32'h0);
         end
         strobe();
         chk(code(ch), ex[n]);
         chk(code(oc), a2);
      end
      host_u.rd(8'(dac_sfc_pkg::ADDR_OUT_BASE + 8'(ch * 4)), rv, rsp);
      chk(rv, {20'h0, a});
      chk(rsp, dac_sfc_pkg::RESP_OKAY);
      wr(dac_sfc_pkg::ADDR_CTRL, 32'h800);
      m = $urandom_range(31);
      wr(dac_sfc_pkg::ADDR_MON, m);
      chk({monitor_output_oe, monitor_channel}, {1'b1, m[4:0]});
      wr(dac_sfc_pkg::ADDR_MON, 32'h3F);
      chk(monitor_output_oe, 1'b0);
      over_temp_pin <= 1'b1;
      repeat (8) @(posedge clk);
      chk(amps_powered, 1'b1);
      wr(dac_sfc_pkg::ADDR_CTRL, 32'h40);
      repeat (8) @(posedge clk);
      chk(amps_powered, 1'b0);
      over_temp_pin <= 1'b0;
      repeat (8) @(posedge clk);
      chk(amps_powered, 1'b0);
      wr(dac_sfc_pkg::ADDR_CTRL, 32'hC0);
      repeat (2) @(posedge clk);
      chk(amps_powered, 1'b1);
      wr(dac_sfc_pkg::ADDR_CTRL, 32'h500);
      host_u.rd(dac_sfc_pkg::ADDR_CTRL, rv, rsp);
      chk(rv, 32'h500);
      fifo_enable_pin <= 1'b1;
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({code(ch), internal_reference_select}, 32'h0);
      fifo_enable_pin <= 1'b0;
      host_u.rd(dac_sfc_pkg::ADDR_STATUS, rv, rsp);
      chk(rv[4], 1'b1);
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_A, ch, a));
      chk(rsp, dac_sfc_pkg::RESP_OKAY);
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_A, ch, b));
      chk(rsp, dac_sfc_pkg::RESP_SLVERR);
      repeat (dac_sfc_pkg::WRITE_CYCLES) @(posedge clk);
      wr(dac_sfc_pkg::ADDR_WRITE, dw(dac_sfc_pkg::SEL_DATA_A, ch, b));
      chk(rsp, dac_sfc_pkg::RESP_OKAY);
      strobe();
      chk(code(ch), b);
      parallel_select_pin <= 1'b0;
      repeat (6) @(posedge clk);
      host_u.rd(dac_sfc_pkg::ADDR_STATUS, rv, rsp);
      chk(rv[4], 1'b0);
      stop_test();
   end
endmodule
bind dac_special_function_control dac_sfc_asserts chk_u (.*);

// ---- common/dac_sfc_pkg.sv ----
// How it works
// - Toggle is enabled per group of eight channels by its own group bit.
// - Every one of 32 channels holds an A and a B data register.
// - Writes to a B register are dropped unless its group toggles.
// - First strobe with toggle shows A, each later strobe swaps A and B.
// - First strobe after toggle is disabled updates outputs from A registers.
// - Monitor mux routes the chosen channel; address 63 floats the monitor output.
// - Thermal shutdown is armed only while the thermal monitor enable is set.
// - When armed, over-temperature powers down all output amplifiers.
// - External reference is selected after power-up until software picks internal.
// - One bit selects internal reference, another picks 2.5 V or 1.25 V.
// - Reset loads defaults and holds outputs at zero until a valid write.
// - Hardware reset performs the same default load as power-on reset.
// - FIFO buffering exists only when the parallel interface is selected.
// - FIFO enable pin is sampled only during reset initialisation.
// - With FIFO enabled a parallel write is accepted every 40 ns.
// - In FIFO operation all 32 channels update within 11.5 microseconds.
package dac_sfc_pkg;
   localparam int NUM_CH = 32;
   localparam int DATA_W = 12;
   localparam int GROUP_SIZE = 8;
   localparam int NUM_GROUPS = NUM_CH / GROUP_SIZE;
   localparam logic [4:0] CTRL_ADDR = 5'h0C;
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_DATA_A = 2'h3;
   localparam logic [1:0] SEL_DATA_B = 2'h2;
   localparam logic [5:0] MON_OFF_ADDR = 6'h3F;
   // Control word layout.
   localparam int CR_TOGGLE_LSB = 0;
   localparam int CR_THERM_BIT = 6;
   localparam int CR_INTREF_BIT = 8;
   localparam int CR_REFVAL_BIT = 10;
   localparam int CR_MON_BIT = 11;
   localparam int CR_PWRUP_BIT = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Register map, byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WRITE = 8'h04;
   localparam logic [7:0] ADDR_MON = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_STROBE = 8'h10;
   localparam logic [7:0] ADDR_OUT_BASE = 8'h80;
   // Write port word: [11:0] data, [16:12] channel, [18:17] select.
   localparam int WR_ADDR_LSB = 12;
   localparam int WR_SEL_LSB = 17;
   // Timing.
   localparam int CLK_MHZ = 200;
   localparam int WRITE_CYCLE_NS = 40;
   localparam int WRITE_CYCLES = (WRITE_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int UPDATE_NS = 11500;
   localparam int UPDATE_CYCLES = (UPDATE_NS * CLK_MHZ) / 1000;
   localparam int UPD_PER_CH = UPDATE_CYCLES / NUM_CH;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/dac_special_function_control.sv ----
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dac_special_function_control #(
   parameter int UPD_CYCLES_PER_CH = dac_sfc_pkg::UPD_PER_CH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic fifo_enable_pin,
   input wire logic parallel_select_pin,
   input wire logic over_temp_pin,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [dac_sfc_pkg::NUM_CH*dac_sfc_pkg::DATA_W-1:0] dac_code,
   output logic amps_powered,
   output logic internal_reference_select,
   output logic reference_value_bit,
   output logic [4:0] monitor_channel,
   output logic monitor_output_oe
);
   localparam int NC = dac_sfc_pkg::NUM_CH;
   localparam int DW = dac_sfc_pkg::DATA_W;
   localparam int NG = dac_sfc_pkg::NUM_GROUPS;

   initial begin
      if (UPD_CYCLES_PER_CH < 1 ||
          UPD_CYCLES_PER_CH * NC > dac_sfc_pkg::UPDATE_CYCLES) begin
         $error("Per-channel update time out of range.");
      end
   end

   // The update sequencer walks the channels one at a time after a strobe.
   // In FIFO mode each slot is stretched so that a full pass fits the
   // documented update budget; otherwise a slot is a single cycle.
   typedef enum logic [1:0] {
      UPD_IDLE = 2'b00,
      UPD_RUN = 2'b01
   } upd_state_t;

   // Pin synchronisers: a change counts once stages two and three agree.
   logic [2:0] fifo_s_r, par_s_r, temp_s_r;
   logic fifo_pin_r, par_pin_r, temp_pin_r;
   always_ff @(posedge clk) begin
      fifo_s_r <= {fifo_s_r[1:0], fifo_enable_pin};
      par_s_r <= {par_s_r[1:0], parallel_select_pin};
      temp_s_r <= {temp_s_r[1:0], over_temp_pin};
      if (fifo_s_r[2] == fifo_s_r[1]) begin
         fifo_pin_r <= fifo_s_r[2];
      end
      if (par_s_r[2] == par_s_r[1]) begin
         par_pin_r <= par_s_r[2];
      end
      if (temp_s_r[2] == temp_s_r[1]) begin
         temp_pin_r <= temp_s_r[2];
      end
   end

   // Each channel keeps an A and a B code plus the code it shows now.
   // The shown code only moves when the sequencer reaches the channel,
   // so a data write alone never disturbs an output.
   // Storage.
   logic [DW-1:0] reg_a_r [NC];
   logic [DW-1:0] reg_b_r [NC];
   logic [DW-1:0] out_r [NC];
   logic [NC-1:0] show_b_r;
   logic [NC-1:0] toggled_r;
   logic [31:0] ctrl_r;
   logic [5:0] mon_sel_r;
   logic shutdown_r;
   logic fifo_mode_r;
   logic init_r;
   logic written_r;
   logic pend_r;

   // The write side holds address and data until both have arrived, in
   // either order, and refuses further ones while a response is pending.
   // This keeps one write in flight and avoids a skid buffer.
   // Every register takes one full aligned word; partial strobes are an error.
   // Bus slave.
   logic aw_held_r, w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic wr_busy_r;
   logic [7:0] space_cnt_r;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   wire wr_go = aw_held_r && w_held_r && !bvalid_r;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire full_word = (wstrb_r == 4'hF);
   wire hit_ctrl = (awaddr_r == dac_sfc_pkg::ADDR_CTRL);
   wire hit_write = (awaddr_r == dac_sfc_pkg::ADDR_WRITE);
   wire hit_mon = (awaddr_r == dac_sfc_pkg::ADDR_MON);
   wire hit_strobe = (awaddr_r == dac_sfc_pkg::ADDR_STROBE);
   wire wr_known = hit_ctrl || hit_write || hit_mon || hit_strobe;

   // The FIFO paces parallel writes; a write too soon is refused.
   wire fifo_active = fifo_mode_r && par_pin_r;
   wire write_paced = !fifo_active || (space_cnt_r == 8'h00);

   // Decoded data-port write.
   wire [DW-1:0] w_code = wdata_r[DW-1:0];
   wire [4:0] w_ch = wdata_r[dac_sfc_pkg::WR_ADDR_LSB +: 5];
   wire [1:0] w_sel = wdata_r[dac_sfc_pkg::WR_SEL_LSB +: 2];
   wire data_wr = wr_go && hit_write && full_word && write_paced;
   wire is_ctrl_wr = data_wr && (w_sel == dac_sfc_pkg::SEL_CTRL)
      && (w_ch == dac_sfc_pkg::CTRL_ADDR);
   wire is_a_wr = data_wr && (w_sel == dac_sfc_pkg::SEL_DATA_A);
   wire is_b_wr = data_wr && (w_sel == dac_sfc_pkg::SEL_DATA_B);
   wire direct_ctrl = wr_go && hit_ctrl && full_word;
   wire ctrl_load = is_ctrl_wr || direct_ctrl;
   wire [31:0] ctrl_new = direct_ctrl ? wdata_r :
      {20'h0, wdata_r[DW-1:0]};
   wire strobe = wr_go && hit_strobe && full_word;

   function automatic logic group_on(input logic [31:0] c,
                                     input logic [4:0] ch);
      group_on = c[dac_sfc_pkg::CR_TOGGLE_LSB +
                   int'(ch) / dac_sfc_pkg::GROUP_SIZE];
   endfunction

   wire b_allowed = group_on(ctrl_r, w_ch);
   wire soft_pwrup = ctrl_load && ctrl_new[dac_sfc_pkg::CR_PWRUP_BIT];
   wire therm_en = ctrl_r[dac_sfc_pkg::CR_THERM_BIT];
   wire wr_err = !wr_known || !full_word || (hit_write && !write_paced);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= dac_sfc_pkg::RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_err ? dac_sfc_pkg::RESP_SLVERR
               : dac_sfc_pkg::RESP_OKAY;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Reads answer one cycle after the address is taken.
   // The output codes can be read back so software can see toggle state.
   // Unmapped addresses answer with an error and zero data.
   // Read side.
   wire [7:0] ra = s_axi_araddr;
   wire ra_out = (ra >= dac_sfc_pkg::ADDR_OUT_BASE) && (ra[1:0] == 2'b00);
   wire [4:0] ra_ch = ra[6:2];
   wire [31:0] status_word = {26'h0, written_r, fifo_active, pend_r,
      shutdown_r, therm_en, amps_powered};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= dac_sfc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r <= dac_sfc_pkg::RESP_OKAY;
         if (ra == dac_sfc_pkg::ADDR_CTRL) begin
            rdata_r <= ctrl_r;
         end else if (ra == dac_sfc_pkg::ADDR_MON) begin
            rdata_r <= {26'h0, mon_sel_r};
         end else if (ra == dac_sfc_pkg::ADDR_STATUS) begin
            rdata_r <= status_word;
         end else if (ra_out) begin
            rdata_r <= {20'h0, out_r[ra_ch]};
         end else begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= dac_sfc_pkg::RESP_SLVERR;
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // The FIFO mode is latched once, right after reset, so a later change
   // of the pin has no effect until the next reset.
   // The soft power-up bit is a command and never stays set in the register.
   // Over temperature wins over any clear in the same cycle.
   // Control, reference, monitor, thermal state.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= dac_sfc_pkg::CTRL_RESET;
         mon_sel_r <= dac_sfc_pkg::MON_OFF_ADDR;
         shutdown_r <= 1'b0;
         init_r <= 1'b1;
         fifo_mode_r <= 1'b0;
         space_cnt_r <= 8'h00;
         written_r <= 1'b0;
      end else begin
         init_r <= 1'b0;
         if (init_r) begin
            fifo_mode_r <= fifo_pin_r;
         end
         if (ctrl_load) begin
            ctrl_r <= ctrl_new;
            ctrl_r[dac_sfc_pkg::CR_PWRUP_BIT] <= 1'b0;
         end
         if (wr_go && hit_mon && full_word) begin
            mon_sel_r <= wdata_r[5:0];
         end
         if (therm_en && temp_pin_r) begin
            shutdown_r <= 1'b1;
         end else if (soft_pwrup && !temp_pin_r) begin
            shutdown_r <= 1'b0;
         end else if (!therm_en) begin
            shutdown_r <= 1'b0;
         end
         if (data_wr && fifo_active) begin
            space_cnt_r <= 8'(dac_sfc_pkg::WRITE_CYCLES - 1);
         end else if (space_cnt_r != 8'h00) begin
            space_cnt_r <= space_cnt_r - 8'h01;
         end
         if (is_a_wr || (is_b_wr && b_allowed)) begin
            written_r <= 1'b1;
         end
      end
   end

   assign amps_powered = !shutdown_r;
   assign internal_reference_select = ctrl_r[dac_sfc_pkg::CR_INTREF_BIT];
   assign reference_value_bit = ctrl_r[dac_sfc_pkg::CR_REFVAL_BIT];
   assign monitor_channel = mon_sel_r[4:0];
   assign monitor_output_oe = ctrl_r[dac_sfc_pkg::CR_MON_BIT]
      && (mon_sel_r != dac_sfc_pkg::MON_OFF_ADDR);

   // Output update sequencer: one channel per slot, 32 slots within 11.5 us in FIFO mode.
   upd_state_t upd_state_r;
   logic [4:0] upd_ch_r;
   logic [15:0] upd_cnt_r;
   wire upd_slot = (upd_cnt_r == 16'h0000);
   wire upd_last = upd_slot && (upd_ch_r == 5'(NC - 1));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upd_state_r <= UPD_IDLE;
         upd_ch_r <= 5'h00;
         upd_cnt_r <= 16'h0000;
         pend_r <= 1'b0;
      end else begin
         case (upd_state_r)
            UPD_IDLE: begin
               if (strobe) begin
                  pend_r <= 1'b1;
                  upd_ch_r <= 5'h00;
                  upd_cnt_r <= fifo_active ?
                     16'(UPD_CYCLES_PER_CH - 1) : 16'h0000;
                  upd_state_r <= UPD_RUN;
               end
            end
            UPD_RUN: begin
               if (!upd_slot) begin
                  upd_cnt_r <= upd_cnt_r - 16'h0001;
               end else if (upd_last) begin
                  pend_r <= 1'b0;
                  upd_state_r <= UPD_IDLE;
               end else begin
                  upd_ch_r <= upd_ch_r + 5'h01;
                  upd_cnt_r <= fifo_active ?
                     16'(UPD_CYCLES_PER_CH - 1) : 16'h0000;
               end
            end
            default: begin
               upd_state_r <= UPD_IDLE;
            end
         endcase
      end
   end

   // Per-channel logic: data registers, toggle phase and shown code.
   // A channel whose group is not toggling is loaded from its A code at each update, and
   // its B register ignores writes.
   // The first strobe after toggling starts shows A, later strobes swap.
   // Outputs read as zero until the first valid data write after reset.
   genvar gi;
   generate
      for (gi = 0; gi < NC; gi++) begin : g_ch
         wire grp = ctrl_r[dac_sfc_pkg::CR_TOGGLE_LSB +
            gi / dac_sfc_pkg::GROUP_SIZE];
         wire hit = (w_ch == 5'(gi));
         wire upd_now = (upd_state_r == UPD_RUN) && upd_slot
            && (upd_ch_r == 5'(gi));
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               reg_a_r[gi] <= '0;
               reg_b_r[gi] <= '0;
               out_r[gi] <= '0;
               show_b_r[gi] <= 1'b0;
               toggled_r[gi] <= 1'b0;
            end else begin
               if (is_a_wr && hit) begin
                  reg_a_r[gi] <= w_code;
               end
               if (is_b_wr && hit && grp) begin
                  reg_b_r[gi] <= w_code;
               end
               if (upd_now) begin
                  if (grp && toggled_r[gi]) begin
                     show_b_r[gi] <= !show_b_r[gi];
                     out_r[gi] <= show_b_r[gi] ? reg_a_r[gi] : reg_b_r[gi];
                  end else begin
                     show_b_r[gi] <= 1'b0;
                     out_r[gi] <= reg_a_r[gi];
                  end
                  toggled_r[gi] <= grp;
               end
            end
         end
         assign dac_code[gi*DW +: DW] = written_r ? out_r[gi] : '0;
      end
   endgenerate
endmodule
